// ---- verilog/srba_rx_status.v ----
// receive polarity, break, idle and activity status of the serial receiver
//
// Overview of operation
// - rx_polarity_invert set inverts sampled receive pin before any processing.
// - inversion applies to data, start, stop, break and idle detection.
// - wake_idle_flag_select 0: idle waking standby receiver does not set idle.
// - wake_idle_flag_select 1: idle waking standby receiver sets idle flag.
// - normal break: 10 low bit times, 11 in 9-bit format.
// - long break enabled: 11 low bit times, 12 in 9-bit format.
// - long break enabled blocks framing error and buffer full flags.
// - rx_active_flag sets when a low start bit is first seen, before the mid-bit check.
// - rx_active_flag clears on idle line; zero means awaiting start.
// - break detected with long break enabled sets line_break_flag; w1c.
// - rx_edge_flag sets on falling edge, rising when inverted.
// - format select 1 means 9-bit data, one extra bit in data and break; idle stays 10 bits.
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "srba_map.vh"
module srba_rx_status (
  input  wire                    sys_clk_i,
  input  wire                    reset_i,
  input  wire                    rxd_i,
  input  wire [`SRBA_ADDR_W-1:0] addr_i,
  input  wire [7:0]              wdata_i,
  input  wire                    wr_i,
  input  wire                    rd_i,
  output reg  [7:0]              rdata_o,
  output reg                     rx_active_o,
  output reg                     line_break_o
);
  localparam ST_IDLE  = 2'b00;
  localparam ST_START = 2'b01;
  localparam ST_DATA  = 2'b10;
  localparam ST_STOP  = 2'b11;

  reg  [7:0]  status2_ff;
  reg  [7:0]  ctrl_ff;
  reg  [15:0] baud_ff;
  reg  [7:0]  rdata_ff;
  reg         rx_buffer_full_flag_ff;
  reg         idle_ff;
  reg         fe_ff;
  reg  [1:0]  state_ff;
  reg  [3:0]  ovs_ff;
  reg  [3:0]  bit_ff;
  reg  [8:0]  shift_ff;
  reg  [3:0]  low_ff;
  reg  [3:0]  high_ff;
  reg         brk_seen_ff;
  reg         idle_armed_ff;
  reg         rx_prev_ff;
  reg         mark_ff;
  wire        tick;
  wire        rx;
  wire        fmt9;
  wire        long_break_detect_enable;
  wire [3:0]  brk_thr;
  wire [3:0]  last_bit;
  wire        samp;
  wire        wr_s2;
  wire        wr_s1;
  wire        edge_ev;
  wire        brk_ev;
  wire        idle_ev;
  wire        stop_ev;
  wire        set_idle;

  function sel;
    input [`SRBA_ADDR_W-1:0] a;
    input [`SRBA_ADDR_W-1:0] b;
    input                    s;
    begin
      sel = s && (a == b);
    end
  endfunction

  srba_baud_tick u_tick (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .divisor_i (baud_ff),
    .tick_o    (tick)
  );

  assign rx       = rxd_i ^ status2_ff[`SRBA_S2_RX_POLARITY_INVERT];
  assign fmt9     = ctrl_ff[`SRBA_CT_FMT9];
  assign long_break_detect_enable    = status2_ff[`SRBA_S2_LONG_BREAK_DETECT_ENABLE];
  assign brk_thr  = `SRBA_BRK_BASE + {3'b000, fmt9} + {3'b000, long_break_detect_enable};
  assign last_bit = fmt9 ? `SRBA_BITS9 : `SRBA_BITS8;
  // no sampling while disabled: the frozen phase could sit at mid-bit
  assign samp     = tick && ctrl_ff[`SRBA_CT_RE] &&
                    (ovs_ff == `SRBA_OVS_MID);
  assign wr_s2    = sel(addr_i, `SRBA_ADDR_STATUS2, wr_i);
  assign wr_s1    = sel(addr_i, `SRBA_ADDR_STATUS1, wr_i);
  // fall of the inverted level is the active pin edge in both polarities
  assign edge_ev  = rx_prev_ff && !rx;
  assign brk_ev   = samp && !rx && (low_ff + 4'h1 == brk_thr) && !brk_seen_ff;
  assign idle_ev  = samp && rx && idle_armed_ff &&
                    (high_ff + 4'h1 == `SRBA_IDLE_BITS);
  assign stop_ev  = samp && (state_ff == ST_STOP);
  assign set_idle = idle_ev && (!ctrl_ff[`SRBA_CT_STBY] ||
                                status2_ff[`SRBA_S2_WIDSEL]);

  // receive state machine on the oversampling enable
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_ff <= ST_IDLE;
      ovs_ff   <= 4'h0;
      bit_ff   <= 4'h0;
      shift_ff <= 9'h000;
    end else if (!ctrl_ff[`SRBA_CT_RE]) begin
      state_ff <= ST_IDLE;
    end else if (tick) begin
      ovs_ff <= ovs_ff + 4'h1;
      case (state_ff)
        ST_IDLE: begin
          // after a low stop bit wait for a mark, so a held break keeps
          // its sampling phase and the break count is not cut short
          if (!rx && mark_ff) begin
            state_ff <= ST_START;
            ovs_ff   <= 4'h0;
          end
        end
        ST_START: begin
          // false start rejected at mid-bit
          if (samp) begin
            state_ff <= rx ? ST_IDLE : ST_DATA;
            bit_ff   <= 4'h0;
          end
        end
        ST_DATA: begin
          if (samp) begin
            shift_ff <= {rx, shift_ff[8:1]};
            bit_ff   <= bit_ff + 4'h1;
            if (bit_ff + 4'h1 == last_bit)
              state_ff <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (samp)
            state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // low and high run counters for break and idle detection
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      low_ff        <= 4'h0;
      high_ff       <= 4'h0;
      brk_seen_ff   <= 1'b0;
      idle_armed_ff <= 1'b0;
      rx_prev_ff    <= 1'b1;
      mark_ff       <= 1'b0;
    end else begin
      rx_prev_ff <= rx;
      if (rx)
        mark_ff <= 1'b1;
      else if (state_ff == ST_START)
        mark_ff <= 1'b0;
      if (samp) begin
        if (rx) begin
          low_ff      <= 4'h0;
          brk_seen_ff <= 1'b0;
          if (high_ff != `SRBA_IDLE_BITS)
            high_ff <= high_ff + 4'h1;
        end else begin
          high_ff       <= 4'h0;
          idle_armed_ff <= 1'b1;
          if (low_ff != `SRBA_RUN_MAX)
            low_ff <= low_ff + 4'h1;
          if (brk_ev)
            brk_seen_ff <= 1'b1;
        end
        if (idle_ev)
          idle_armed_ff <= 1'b0;
      end
    end
  end

  // flags and registers; hardware set wins over software clear
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      status2_ff <= `SRBA_S2_RST;
      ctrl_ff    <= `SRBA_CT_RST;
      baud_ff    <= `SRBA_BAUD_RST;
      rdata_ff   <= 8'h00;
      rx_buffer_full_flag_ff    <= 1'b0;
      idle_ff    <= 1'b0;
      fe_ff      <= 1'b0;
    end else begin
      if (wr_s2) begin
        status2_ff[`SRBA_S2_RX_POLARITY_INVERT]  <= wdata_i[`SRBA_S2_RX_POLARITY_INVERT];
        status2_ff[`SRBA_S2_WIDSEL] <= wdata_i[`SRBA_S2_WIDSEL];
        status2_ff[`SRBA_S2_BRKLEN] <= wdata_i[`SRBA_S2_BRKLEN];
        status2_ff[`SRBA_S2_LONG_BREAK_DETECT_ENABLE]  <= wdata_i[`SRBA_S2_LONG_BREAK_DETECT_ENABLE];
      end
      if ((wr_s2 && wdata_i[`SRBA_S2_LBRK]))
        status2_ff[`SRBA_S2_LBRK] <= 1'b0;
      if (brk_ev && long_break_detect_enable)
        status2_ff[`SRBA_S2_LBRK] <= 1'b1;
      if (wr_s2 && wdata_i[`SRBA_S2_EDGE])
        status2_ff[`SRBA_S2_EDGE] <= 1'b0;
      if (edge_ev)
        status2_ff[`SRBA_S2_EDGE] <= 1'b1;
      // write data bit 0 ignored here
      if (state_ff != ST_IDLE)
        status2_ff[`SRBA_S2_RAF] <= 1'b1;
      else if (idle_ev)
        status2_ff[`SRBA_S2_RAF] <= 1'b0;
      if (sel(addr_i, `SRBA_ADDR_CTRL, wr_i))
        ctrl_ff <= wdata_i;
      if (sel(addr_i, `SRBA_ADDR_BAUD, wr_i))
        baud_ff <= {8'h00, wdata_i};
      if (set_idle && ctrl_ff[`SRBA_CT_STBY])
        ctrl_ff[`SRBA_CT_STBY] <= 1'b0;
      if (wr_s1 && wdata_i[`SRBA_S1_IDLE])
        idle_ff <= 1'b0;
      if (wr_s1 && wdata_i[`SRBA_S1_FE])
        fe_ff <= 1'b0;
      if (sel(addr_i, `SRBA_ADDR_DATA, rd_i))
        rx_buffer_full_flag_ff <= 1'b0;
      if (set_idle)
        idle_ff <= 1'b1;
      // wake from standby even when idle flag is suppressed
      if (idle_ev && ctrl_ff[`SRBA_CT_STBY])
        ctrl_ff[`SRBA_CT_STBY] <= 1'b0;
      if (stop_ev && !long_break_detect_enable && !ctrl_ff[`SRBA_CT_STBY]) begin
        rx_buffer_full_flag_ff  <= 1'b1;
        // 8-bit frames end one place higher in the shifter
        rdata_ff <= fmt9 ? shift_ff[7:0] : shift_ff[8:1];
        if (!rx)
          fe_ff <= 1'b1;
      end
    end
  end

  // read data in the cycle after the strobe; unmapped reads zero
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      rdata_o      <= 8'h00;
      rx_active_o  <= 1'b0;
      line_break_o <= 1'b0;
    end else begin
      rx_active_o  <= status2_ff[`SRBA_S2_RAF];
      line_break_o <= status2_ff[`SRBA_S2_LBRK];
      rdata_o      <= 8'h00;
      if (rd_i) begin
        case (addr_i)
          `SRBA_ADDR_STATUS2: rdata_o <= status2_ff;
          `SRBA_ADDR_CTRL:    rdata_o <= ctrl_ff;
          `SRBA_ADDR_STATUS1: rdata_o <= {2'b00, rx_buffer_full_flag_ff, idle_ff,
                                          2'b00, fe_ff, 1'b0};
          `SRBA_ADDR_DATA:    rdata_o <= rdata_ff;
          `SRBA_ADDR_BAUD:    rdata_o <= baud_ff[7:0];
          default:            rdata_o <= 8'h00;
        endcase
      end
    end
  end
endmodule // srba_rx_status
`default_nettype wire

// ---- common/srba_map.vh ----
// register map, field positions and timing constants of the rx status slice
`ifndef SRBA_MAP_VH
`define SRBA_MAP_VH
`define SRBA_ADDR_W         4
`define SRBA_ADDR_STATUS2   4'h0
`define SRBA_ADDR_CTRL      4'h1
`define SRBA_ADDR_STATUS1   4'h2
`define SRBA_ADDR_DATA      4'h3
`define SRBA_ADDR_BAUD      4'h4
// status two fields
`define SRBA_S2_LBRK        7
`define SRBA_S2_EDGE        6
`define SRBA_S2_RX_POLARITY_INVERT       4
`define SRBA_S2_WIDSEL      3
`define SRBA_S2_BRKLEN      2
`define SRBA_S2_LONG_BREAK_DETECT_ENABLE       1
`define SRBA_S2_RAF         0
// control fields
`define SRBA_CT_RE          0
`define SRBA_CT_FMT9        1
`define SRBA_CT_STBY        2
// status one fields
`define SRBA_S1_RX_BUFFER_FULL_FLAG        5
`define SRBA_S1_IDLE        4
`define SRBA_S1_FE          1
// reset values
`define SRBA_S2_RST         8'h00
`define SRBA_CT_RST         8'h00
`define SRBA_BAUD_RST       16'h0004
// oversampling phase in ticks, thresholds in bit times
`define SRBA_OVS            4'hf
`define SRBA_OVS_MID        4'h7
`define SRBA_BRK_BASE       4'ha
`define SRBA_IDLE_BITS      4'ha
// data bits per frame and run counter ceiling
`define SRBA_BITS8          4'h8
`define SRBA_BITS9          4'h9
`define SRBA_RUN_MAX        4'hf
`endif

// ---- verilog/srba_baud_tick.v ----
// baud divider: one-cycle enable at sixteen times the bit rate
`timescale 1ns/1ps
`default_nettype none
module srba_baud_tick (
  input  wire        sys_clk_i,
  input  wire        reset_i,
  input  wire [15:0] divisor_i,
  output reg         tick_o
);
  reg [15:0] cnt_ff;
  wire [15:0] nxt_cnt;

  // divisor of zero or one ticks every cycle
  assign nxt_cnt = (cnt_ff + 16'h0001 >= divisor_i) ? 16'h0000
                                                     : cnt_ff + 16'h0001;
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      cnt_ff <= 16'h0000;
      tick_o <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_o <= (nxt_cnt == 16'h0000);
    end
  end
endmodule // srba_baud_tick
`default_nettype wire

// ---- bench/srba_rx_status_assertions.sv ----
// port checker for the rx status slice
`timescale 1ns/1ps
`default_nettype none
module srba_chk (
  input wire logic       sys_clk_i,
  input wire logic       reset_i,
  input wire logic       rxd_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       rx_active_o,
  input wire logic       line_break_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  logic        inv_ff, lbk_ff, f9_ff;
  logic [10:0] lo_ff, hi_ff;
  wire         ln  = rxd_i ^ inv_ff;
  // 24 cycles into the final low bit, ahead of its sample near mid-bit
  wire  [10:0] thr = f9_ff ? 11'd728 : 11'd664;
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      lo_ff  <= 11'd0;
      hi_ff  <= 11'd0;
      inv_ff <= 1'b0;
      lbk_ff <= 1'b0;
      f9_ff  <= 1'b0;
    end else begin
      lo_ff <= ln ? 11'd0 : lo_ff + {10'd0, ~&lo_ff};
      hi_ff <= !ln ? 11'd0 : hi_ff + {10'd0, ~&hi_ff};
      if (wr_i && addr_i == 4'h0) begin
        inv_ff <= wdata_i[4];
        lbk_ff <= wdata_i[1];
      end else if (wr_i && addr_i == 4'h1) begin
        f9_ff <= wdata_i[1];
      end
    end
  end
  a_act_start: assert property ($rose(rx_active_o) |-> hi_ff < 11'd80)
    else $error("active without start bit");
  a_act_idle: assert property ($fell(rx_active_o) |-> hi_ff > 11'd600)
    else $error("active cleared before idle");
  a_act_clear: assert property (hi_ff == 11'd720 |-> !rx_active_o)
    else $error("active kept on idle line");
  a_brk_min: assert property ($rose(line_break_o) |-> lo_ff >= thr)
    else $error("break flagged too early");
  a_brk_due: assert property (lbk_ff && lo_ff == thr + 11'd48 |-> line_break_o)
    else $error("break not flagged");
  a_brk_off: assert property (!lbk_ff && !$past(lbk_ff) && !line_break_o
    |=> !line_break_o) else $error("break flag while disabled");
  a_brk_clr: assert property (wr_i && addr_i == 4'h0 && wdata_i[7]
    && lo_ff == 11'd0 |-> ##3 !line_break_o) else $error("break not cleared");
  a_raf_read: assert property (rd_i && addr_i == 4'h0 |=>
    rdata_o[0] == rx_active_o || rdata_o[0] == $past(rx_active_o))
    else $error("active bit read wrong");
  c_brk: cover property ($rose(line_break_o));
  c_idle: cover property ($fell(rx_active_o));
  c_rd: cover property (rd_i && addr_i == 4'h0 ##1 rdata_o[0]);
endmodule // srba_chk
bind srba_rx_status srba_chk srba_chk_inst (.sys_clk_i(sys_clk_i),
  .reset_i(reset_i), .rxd_i(rxd_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_active_o(rx_active_o),
  .line_break_o(line_break_o));
`default_nettype wire

// ---- bench/srba_node.sv ----
// remote serial node driving the receive pin
`timescale 1ns/1ps
`default_nettype none
module srba_node (
  input  wire logic sys_clk_i,
  input  wire logic inv_i,
  output logic      rxd_o
);
  logic lvl_ff = 1'b1;
  // idle level follows the polarity so a flip never fakes a start
  assign rxd_o = lvl_ff ^ inv_i;
  task automatic hold(input logic v, input int n);
    @(posedge sys_clk_i);
    lvl_ff <= v;
    repeat (n * 64 - 1) @(posedge sys_clk_i);
  endtask
  task automatic frame(input logic [7:0] d);
    hold(1'b0, 1);
    for (int i = 0; i < 8; i++) hold(d[i], 1);
    hold(1'b1, 1);
  endtask
endmodule // srba_node
`default_nettype wire

// ---- bench/tb_srba_rx_status.sv ----
// self-checking bench for the rx status slice
`timescale 1ns/1ps
`default_nettype none
module tb_srba_rx_status;
  logic       sys_clk_i = 1'b0;
  logic       reset_i = 1'b1;
  logic       inv = 1'b0;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  wire        rxd, act, brk;
  wire  [7:0] rdata_o;
  int         errors = 0;
  int         samples_checked = 0;
  srba_rx_status srba_rx_status_inst (.sys_clk_i(sys_clk_i),
    .reset_i(reset_i), .rxd_i(rxd), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_active_o(act),
    .line_break_o(brk));
  srba_node srba_node_inst (.sys_clk_i(sys_clk_i), .inv_i(inv),
    .rxd_o(rxd));
  initial forever #4 sys_clk_i = ~sys_clk_i;
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [7:0] s,
      input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic rc(input string n, input logic [3:0] a,
      input logic [7:0] m, input logic [7:0] e);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(n, rdata_o & m, e);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge sys_clk_i);
    errors++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rc("s2", 4'h0, 8'hff, 8'h00);
    rc("baud", 4'h4, 8'hff, 8'h04);
    rc("unmapped", 4'hf, 8'hff, 8'h00);
    wr(4'h0, 8'h01);
    rc("raf", 4'h0, 8'hff, 8'h00);
    wr(4'h1, 8'h01);
    $display("reset test done");
    for (int i = 0; i < 2; i++) begin
      wr(4'h0, {3'b110, i[0], 4'h0});
      inv <= i[0];
      srba_node_inst.hold(1'b1, 12);
      wr(4'h0, {3'b110, i[0], 4'h0});
      wr(4'h2, 8'h12);
      fork
        srba_node_inst.frame(8'h5a);
        begin
          repeat (300) @(posedge sys_clk_i);
          rc("raf", 4'h0, 8'h01, 8'h01);
          chk("act pin", {7'h00, act}, 8'h01);
        end
      join
      srba_node_inst.hold(1'b1, 12);
      rc("s2", 4'h0, 8'hff, {3'b010, i[0], 4'h0});
      chk("act pin idle", {7'h00, act}, 8'h00);
      rc("s1", 4'h2, 8'h32, 8'h30);
      rc("data", 4'h3, 8'hff, 8'h5a);
    end
    $display("polarity test done");
    for (int i = 0; i < 2; i++) begin
      wr(4'h0, {4'h1, i[0], 3'b000});
      wr(4'h2, 8'h12);
      wr(4'h1, 8'h05);
      srba_node_inst.frame(8'ha5);
      srba_node_inst.hold(1'b1, 12);
      rc("idle", 4'h2, 8'h10, {3'b000, i[0], 4'h0});
      rc("standby", 4'h1, 8'h04, 8'h00);
    end
    $display("standby test done");
    for (int i = 0; i < 2; i++) begin
      wr(4'h1, {6'h00, i[0], 1'b1});
      wr(4'h0, 8'h12);
      wr(4'h2, 8'h12);
      srba_node_inst.hold(1'b0, 10 + i);
      srba_node_inst.hold(1'b1, 12);
      rc("short brk", 4'h0, 8'h80, 8'h00);
      srba_node_inst.hold(1'b0, 13);
      srba_node_inst.hold(1'b1, 12);
      rc("long brk", 4'h0, 8'h80, 8'h80);
      chk("brk pin", {7'h00, brk}, 8'h01);
      rc("fe rx_buffer_full_flag", 4'h2, 8'h22, 8'h00);
      wr(4'h0, 8'h92);
      rc("brk clr", 4'h0, 8'h80, 8'h00);
      chk("brk pin clr", {7'h00, brk}, 8'h00);
    end
    wr(4'h0, 8'h10);
    wr(4'h2, 8'h12);
    srba_node_inst.hold(1'b0, 13);
    srba_node_inst.hold(1'b1, 12);
    rc("fe", 4'h2, 8'h02, 8'h02);
    rc("no brk", 4'h0, 8'h80, 8'h00);
    $display("break test done");
    end_sim;
  end
endmodule // tb_srba_rx_status
`default_nettype wire
